/* event_priority_consts.svh */
// timing-free constants of the event priority and vectoring block
// assumes: included by the package and the design file by bare name
`ifndef EVENT_PRIORITY_CONSTS_SVH
`define EVENT_PRIORITY_CONSTS_SVH

// number of exception sources and width of the priority class field
`define EVP_NUM_EXC 8
`define EVP_CLASS_W 3
// handler spacing for ordinary entries, in bytes
`define EVP_SLOT_BYTES 32'h0000_0004
// first offset of the ordinary handler slots
`define EVP_SLOT_BASE 32'h0000_0100
// large spacing for the critical entries, in bytes
`define EVP_CRIT_BYTES 32'h0000_0040
// sources below this index are critical and get large spacing
`define EVP_NUM_CRIT 2
// class given to interrupt requests and to idle thread
`define EVP_CLASS_IRQ 3'h1
`define EVP_CLASS_IDLE 3'h0
// reset value of the vector base
`define EVP_BASE_RESET 32'h0000_0000

`endif

/* event_priority_pkg.sv */
// types for the event priority and vectoring block
// assumes: constants come from the guarded header
`include "event_priority_consts.svh"

package event_priority_pkg;

  // accepted-event redirect toward the fetch unit
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [2:0] class_lvl;
  } redirect_t;

  // state of the sequencer
  typedef enum logic [0:0] {
    st_run,
    st_redirect
  } evp_state_t;

  // whole register state of the block
  typedef struct packed {
    evp_state_t st;
    logic [31:0] event_vector_base;
    logic [2:0] cur_class;
    logic halt;
    redirect_t redir;
    logic irq_ack; // pulse marking an accepted interrupt
  } evp_regs_t;

endpackage

/* event_priority_vectoring.sv */
// event prioritiser and handler address former of a 32-bit core
// assumes: core clock, core reset; fetch unit obeys halt and redirect;
// interrupt controller gives an autovectored service address with request
//
// Operation
// [RULE_01] fixed priority per source, lowest index wins
// [RULE_02] only higher class preempts running handler
// [RULE_03] accepted event halts stream, redirects fetch
// [RULE_04] ordinary handlers at base plus four-byte slots
// [RULE_05] critical events get larger offset spacing
// [RULE_06] interrupts branch to controller-supplied routine address
// [RULE_07] vector base register sampled at acceptance
`timescale 1ns/1ns
`include "event_priority_consts.svh"

module event_priority_vectoring #(
  parameter int NUM_EXC = `EVP_NUM_EXC
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // exception sources, one bit each, index 0 highest priority
  input wire logic [NUM_EXC-1:0] i_exc_req,
  // class of each exception source, flattened
  input wire logic [NUM_EXC*3-1:0] i_exc_class,
  // autovectored interrupt request from the interrupt controller
  input wire logic i_irq_req,
  input wire logic [31:0] i_interrupt_service_routine,
  // vector base write from the core's system register port
  input wire logic i_base_we,
  input wire logic [31:0] i_base_wdata,
  // handler finished, return to the interrupted class
  input wire logic i_handler_ret,
  input wire logic [2:0] i_ret_class,
  // fetch control, interrupt acknowledge and vector base readback
  output logic o_halt,
  output logic o_redirect_valid,
  output logic [31:0] o_redirect_addr,
  output logic [2:0] o_cur_class,
  output logic o_irq_ack,
  output logic [31:0] o_event_vector_base
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // handler offset for one exception index
  function automatic logic [31:0] exc_offset(input int unsigned idx);
    logic [31:0] i32;
    i32 = 32'(idx);
    if (idx < `EVP_NUM_CRIT) begin
      // critical entries sit on wide spacing so a routine fits inline
      exc_offset = i32 * `EVP_CRIT_BYTES; // RULE_05
    end else begin
      exc_offset = `EVP_SLOT_BASE +
                   (i32 - 32'(`EVP_NUM_CRIT)) * `EVP_SLOT_BYTES; // RULE_04
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  event_priority_pkg::evp_regs_t r; // registered state
  event_priority_pkg::evp_regs_t next_r; // next state
  logic sel_found; // some exception is eligible
  logic [31:0] sel_off; // offset of the winning exception
  logic [2:0] sel_class; // class of the winning exception
  logic take_irq; // interrupt wins this cycle
  // limitation: a return that meets an acceptance or the settle cycle is
  // dropped, so the core must hold it off until the redirect is done

  ////////////////////////////////////////////////////////////////////////
  // priority resolution

  // scan from lowest priority upward so the lowest index is kept last
  always_comb begin
    sel_found = 1'b0;
    sel_off = 32'h0000_0000;
    sel_class = 3'h0;
    for (int i = NUM_EXC - 1; i >= 0; i--) begin
      if (i_exc_req[i] &&
          i_exc_class[i*3 +: 3] > r.cur_class) begin // RULE_02
        sel_found = 1'b1; // RULE_01
        sel_off = exc_offset(i);
        sel_class = i_exc_class[i*3 +: 3];
      end
    end
    // exceptions outrank interrupts; irq still needs a higher class
    take_irq = !sel_found && i_irq_req &&
               (`EVP_CLASS_IRQ > r.cur_class); // RULE_02
  end

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_r = r;
    next_r.redir.valid = 1'b0;
    next_r.halt = 1'b0;
    next_r.irq_ack = 1'b0;
    // a write is visible to the next acceptance, not the current one
    if (i_base_we) begin
      next_r.event_vector_base = i_base_wdata; // RULE_07
    end
    unique case (r.st)
      event_priority_pkg::st_run: begin
        if (sel_found) begin
          // stop the stream and point fetch at the handler
          next_r.halt = 1'b1; // RULE_03
          next_r.redir.valid = 1'b1;
          next_r.redir.addr = r.event_vector_base + sel_off; // RULE_07
          next_r.redir.class_lvl = sel_class;
          next_r.cur_class = sel_class;
          next_r.st = event_priority_pkg::st_redirect;
        end else if (take_irq) begin
          next_r.halt = 1'b1; // RULE_03
          next_r.redir.valid = 1'b1;
          next_r.redir.addr = i_interrupt_service_routine; // RULE_06
          next_r.irq_ack = 1'b1; // RULE_06
          next_r.redir.class_lvl = `EVP_CLASS_IRQ;
          next_r.cur_class = `EVP_CLASS_IRQ;
          next_r.st = event_priority_pkg::st_redirect;
        end else if (i_handler_ret) begin
          // return lowers the running class to the interrupted one
          next_r.cur_class = i_ret_class;
        end
      end
      event_priority_pkg::st_redirect: begin
        // one settle cycle so a new decision sees the updated class
        next_r.st = event_priority_pkg::st_run;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r.st <= event_priority_pkg::st_run;
      r.event_vector_base <= `EVP_BASE_RESET;
      r.cur_class <= `EVP_CLASS_IDLE;
      r.halt <= 1'b0;
      r.redir <= '0;
      r.irq_ack <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from flip-flops
  assign o_halt = r.halt;
  assign o_redirect_valid = r.redir.valid;
  assign o_redirect_addr = r.redir.addr;
  assign o_cur_class = r.cur_class;
  assign o_irq_ack = r.irq_ack;
  assign o_event_vector_base = r.event_vector_base;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  AST_PRIO_LOWEST_WINS: assert property ( // RULE_01
    (r.st == event_priority_pkg::st_run) && i_exc_req[0] &&
    i_exc_class[2:0] > r.cur_class
    |=> o_redirect_addr == $past(r.event_vector_base))
    else $error("highest priority source not chosen");
  AST_NO_EQUAL_PREEMPT: assert property ( // RULE_02
    o_redirect_valid |-> o_cur_class > $past(r.cur_class))
    else $error("redirect without higher class");
  AST_HALT_WITH_REDIRECT: assert property ( // RULE_03
    o_redirect_valid |-> o_halt ##1 !o_redirect_valid)
    else $error("redirect not paired with halt");
  AST_ACCEPT_REDIRECTS: assert property ( // RULE_03
    (r.st == event_priority_pkg::st_run) && (sel_found || take_irq)
    |=> o_redirect_valid)
    else $error("accepted event did not redirect");
  AST_IRQ_ADDR: assert property ( // RULE_06
    o_irq_ack |-> o_redirect_addr == $past(i_interrupt_service_routine))
    else $error("irq not sent to supplied address");
  AST_SLOT_SPACING: assert property ( // RULE_04
    (r.st == event_priority_pkg::st_run) && i_exc_req == 8'h04 &&
    i_exc_class[8:6] > r.cur_class
    |=> o_redirect_addr == $past(r.event_vector_base) + `EVP_SLOT_BASE)
    else $error("ordinary slot offset wrong");
  AST_CRIT_SPACING: assert property ( // RULE_05
    (r.st == event_priority_pkg::st_run) && i_exc_req == 8'h02 &&
    i_exc_class[5:3] > r.cur_class
    |=> o_redirect_addr == $past(r.event_vector_base) + `EVP_CRIT_BYTES)
    else $error("critical offset wrong");
  AST_BASE_WRITE: assert property ( // RULE_07
    i_base_we |=> o_event_vector_base == $past(i_base_wdata))
    else $error("vector base not written");
  // an exception and an interrupt in one cycle: the exception is taken
  AST_EXC_OUTRANKS_IRQ: assert property ( // RULE_01
    (r.st == event_priority_pkg::st_run) && sel_found && i_irq_req
    |=> o_redirect_valid && !o_irq_ack)
    else $error("interrupt taken over an exception");
  // a return that meets no acceptance sets the running class
  AST_RET_LOWERS: assert property ( // RULE_02
    (r.st == event_priority_pkg::st_run) && i_handler_ret &&
    !sel_found && !take_irq
    |=> o_cur_class == $past(i_ret_class))
    else $error("return did not restore class");
  // an interrupt at or below the running class must wait
  AST_IRQ_REFUSED: assert property ( // RULE_02
    (r.st == event_priority_pkg::st_run) && i_irq_req && !sel_found &&
    r.cur_class >= `EVP_CLASS_IRQ
    |=> !o_redirect_valid)
    else $error("interrupt preempted an equal class");
  AST_IRQ_CLASS: assert property ( // RULE_06
    o_irq_ack |-> o_redirect_valid && o_cur_class == `EVP_CLASS_IRQ)
    else $error("interrupt redirect carries wrong class");
  // without a write the base must not drift
  AST_BASE_HELD: assert property ( // RULE_07
    !i_base_we |=> $stable(o_event_vector_base))
    else $error("vector base changed without a write");

  COV_EXC: cover property (o_redirect_valid && !o_irq_ack);
  COV_IRQ: cover property (o_irq_ack);
  COV_PREEMPT: cover property (o_redirect_valid ##2 o_redirect_valid);
  COV_RET: cover property (i_handler_ret && !sel_found && !take_irq);

endmodule

/* irq_ctrl_model.sv */
// interrupt controller stand-in giving autovectored requests
// assumes: core clock; request held until the core acknowledges
`timescale 1ns/1ns
module irq_ctrl_model (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // bench command and core acknowledge
  input wire logic i_fire,
  input wire logic [31:0] i_addr,
  input wire logic i_ack,
  // request toward the core
  output logic o_req,
  output logic [31:0] o_isr
);
  // hold request and routine address until the ack is seen
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_req <= 1'b0;
      o_isr <= 32'h0000_0000;
    end else if (i_fire) begin
      o_req <= 1'b1;
      o_isr <= i_addr;
    end else if (i_ack) begin
      o_req <= 1'b0;
      // released: never leave the last address looking valid
      o_isr <= ~o_isr;
    end
  end
endmodule

/* tb.sv */
// bench for the event prioritiser, with an integer reference model
// assumes: irq_ctrl_model beside the design, core clock 100 MHz
`timescale 1ns/1ns
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] req = 8'h00;
  logic [23:0] cls = 24'h000000;
  logic we = 1'b0;
  logic ret = 1'b0;
  logic fire = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] faddr = 32'h0;
  logic [2:0] rcls = 3'h0;
  logic irq, ack, halt, rv;
  logic [31:0] interrupt_service_routine, raddr, vb;
  logic [2:0] cur;
  int mismatches = 0;
  int n_compared = 0;
  int m_cur = 0;
  logic [31:0] m_base = 32'h0;
  logic [31:0] m_addr = 32'h0;
  logic [31:0] lfsr = 32'h0001_0a0a;
  always #5 clk = ~clk;
  event_priority_vectoring i_dut (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_exc_req(req), .i_exc_class(cls), .i_irq_req(irq),
    .i_interrupt_service_routine(interrupt_service_routine), .i_base_we(we),
    .i_base_wdata(wdata), .i_handler_ret(ret), .i_ret_class(rcls),
    .o_halt(halt), .o_redirect_valid(rv), .o_redirect_addr(raddr),
    .o_cur_class(cur), .o_irq_ack(ack), .o_event_vector_base(vb));
  irq_ctrl_model i_irq (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_fire(fire), .i_addr(faddr), .i_ack(ack), .o_req(irq),
    .o_isr(interrupt_service_routine));
  ////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    if (mismatches == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // one exception cycle; a base write rides the same edge on purpose
  task automatic exc(input logic [7:0] r, input logic [23:0] c,
                     input logic w, input logic [31:0] d);
    int win;
    win = -1;
    for (int i = 7; i >= 0; i--)
      if (r[i] && int'(c[3*i+:3]) > m_cur)
        win = i;
    @(posedge clk);
    req <= r;
    cls <= c;
    we <= w;
    wdata <= d;
    @(posedge clk);
    req <= 8'h00;
    we <= 1'b0;
    #1;
    if (win >= 0) begin
      m_addr = m_base + (win < 2 ? 32'(win) * 32'h40
                                 : 32'hf8 + 32'(win) * 32'h4);
      m_cur = int'(c[3*win+:3]);
    end
    if (w)
      m_base = d;
    chk(32'(rv), 32'(win >= 0));
    chk(32'(halt), 32'(win >= 0));
    chk(32'(ack), 32'h0);
    chk(raddr, m_addr);
    chk(32'(cur), 32'(m_cur));
    chk(vb, m_base);
  endtask
  task automatic hret(input logic [2:0] k);
    @(posedge clk);
    ret <= 1'b1;
    rcls <= k;
    @(posedge clk);
    ret <= 1'b0;
    #1;
    m_cur = int'(k);
    chk(32'(cur), 32'(k));
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    // everything idle out of reset, base at its reset value
    chk(vb, 32'h0);
    chk(32'({rv, halt, ack, cur}), 32'h0);
    exc(8'h06, 24'o22222222, 1'b0, 32'h0);
    exc(8'h04, 24'o22222222, 1'b0, 32'h0);
    exc(8'h80, 24'o33333333, 1'b1, 32'h8000_1000);
    exc(8'h01, 24'o77777777, 1'b0, 32'h0);
    // random traffic with returns to random classes
    for (int k = 0; k < 200; k++) begin
      if (k % 4 == 3)
        hret(3'(rnd()));
      exc(8'(rnd()), 24'(rnd()), 1'(rnd()), rnd());
    end
    // autovectored interrupt from idle class
    hret(3'h0);
    @(posedge clk);
    fire <= 1'b1;
    faddr <= rnd();
    @(posedge clk);
    fire <= 1'b0;
    #1;
    n = 0;
    while (rv !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(raddr, faddr);
    chk(32'(ack), 32'h1);
    chk(32'(cur), 32'h1);
    m_cur = 1;
    // a second request at the running class waits; an exception passes
    @(posedge clk);
    fire <= 1'b1;
    faddr <= rnd();
    @(posedge clk);
    fire <= 1'b0;
    exc(8'h08, 24'o00002000, 1'b0, 32'h0);
    hret(3'h0);
    @(posedge clk);
    #1;
    chk(raddr, faddr);
    chk(32'(ack), 32'h1);
    chk(32'(cur), 32'h1);
    // a reset in mid-run restores the base and the idle class
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    m_base = 32'h0;
    m_cur = 0;
    chk(vb, m_base);
    chk(32'({rv, halt, ack, cur}), 32'h0);
    exc(8'h02, 24'o11111111, 1'b0, 32'h0);
    test_done();
  end
  initial begin
    #100000;
    mismatches++;
    test_done();
  end
endmodule
